// ### hw/wake_params.svh
// Constants of the suspend and wake logic: register offsets, fields, resets.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH
// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFS_PMC 8'h00
`define OFS_WCSR 8'h04
`define OFS_ISR 8'h08
`define OFS_GWAKE 8'h0C
`define OFS_HWCFG 8'h10
`define OFS_STATE 8'h14
// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define PMC_MODE_LSB 0
`define PMC_LANEN 2
`define PMC_EDEN 3
`define PMC_WS_LSB 4
`define PMC_READY 6
`define PMC_REINIT 7
`define GW_POL_LSB 16
`define GW_LINKSEL 31
`define MODE_LAN 2'h0
`define MODE_ENERGY 2'h1
`define MODE_MIN 2'h2
`define MODE_CLK 2'h3
`define MODE_RESET 2'h2
`define WS_ENERGY 0
`define WS_LAN 1
`define LAN_EVT_W 5
`define GPIO_LINK 7
`define GPIO_INT_HI 7
`define HWCFG_EXTPHY 0
`endif

// ### hw/wake_pkg.sv
// Types shared by the suspend and wake logic.
// Assumes nothing beyond a SystemVerilog tool.
package wake_pkg;
	// Power states, one-hot
	typedef enum logic [6:0] {
		ST_UNCFG = 7'h01,
		ST_CFG = 7'h02,
		ST_SLP_LAN = 7'h04,
		ST_SLP_ENERGY = 7'h08,
		ST_SLP_MIN = 7'h10,
		ST_SLP_CLK = 7'h20,
		ST_UNPOWERED = 7'h40
	} pwr_state_e;
endpackage

// ### hw/gpio_wake_if.sv
// Bundle between the sleep controller and the GPIO wake detector.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface gpio_wake_if #(parameter int N = 11);
	logic [N-1:0] pinIn;
	logic [N-1:0] wakeEn;
	logic [N-1:0] polarity;
	logic [N-1:0] usable;
	logic linkSel;
	logic linkUp;
	logic [N-1:0] evt;
	modport det (input pinIn, wakeEn, polarity, usable, linkSel, linkUp, output evt);
	modport ctl (output pinIn, wakeEn, polarity, usable, linkSel, linkUp, input evt);
endinterface // gpio_wake_if

// ### hw/gpio_wake_detect.sv
// Per-pin GPIO wake detector: polarity, enable, link-up substitution on pin 7.
// Assumes pin levels already synchronous to core_clk.
`timescale 1ns/1ps
`include "wake_params.svh"
module gpio_wake_detect #(
	parameter int N = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Wake bundle
	gpio_wake_if.det bus
);
	logic [N-1:0] src;
	logic [N-1:0] prev_q;

	// ---------------------------------------------------------------
	// Source selection and edge detect
	// ---------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_pin
		if (i == `GPIO_LINK) begin : g_link
			// Pin level is ignored while link up is selected
			assign src[i] = bus.linkSel ? bus.linkUp : (bus.pinIn[i] ~^ bus.polarity[i]);
		end else begin : g_plain
			assign src[i] = bus.pinIn[i] ~^ bus.polarity[i];
		end
	end
	// Edge, so a held level raises one event only
	assign bus.evt = src & ~prev_q & bus.wakeEn & bus.usable;

	// Previous source level
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= '0;
		end else begin
			prev_q <= src;
		end
	end

	evt_edge_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		|bus.evt |-> |($past(~src) & src)) else $error("event without edge");
endmodule // gpio_wake_detect

// ### hw/suspend_wake_event_logic.sv
// Suspend-state selection and wake-event qualification for a USB Ethernet bridge.
// Assumes a synchronous register port and pulses from the USB core, all on core_clk.
//
// Operation
// - Suspend with select 10b enters minimum-power sleep; 10b is the default.
// - Minimum-power sleep leaves only on host resume or enabled GPIO wake; here USB reset and loss of bus power also leave it.
// - Minimum-power sleep loses PHY state; host must reinitialise PHY after.
// - Suspend with select 11b enters clocks-on sleep.
// - Clocks-on sleep keeps all internal clocks running.
// - Clocks-on sleep wakes on GPIO, link up, or filtered good frame.
// - Good-frame wake sets the LAN bit of the wake status field.
// - Clocks-on sleep drops all frames if any LAN event enable is set.
// - Each sleep state accepts only its listed wake sources.
// - GPIO wake sets its sticky per-pin flag until software clears it.
// - Link-up select makes GPIO7 wake on PHY link up in LAN-wake and clocks-on sleep.
// - GPIOs 0-7 usable for wake only with the internal PHY.
// - GPIOs 8-10 usable for wake with internal or external PHY.
// - Suspend select keeps its value across a wake.
// - Remote wake on GPIO, Wake-on-LAN or energy-detect events.
// - Select 00b enters LAN-wake sleep, 01b energy-detect sleep.
// - Suspend from unconfigured enters only minimum-power, wakes to unconfigured.
// - Deconfiguration resets the suspend select to 10b.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "wake_params.svh"
module suspend_wake_event_logic #(
	parameter int NGPIO = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	// USB core events
	input wire logic suspendReq,
	input wire logic hostResume,
	input wire logic usbReset,
	input wire logic configDone,
	input wire logic deconfigure,
	input wire logic busPowerSense,
	// Network events
	input wire logic lanWakeEvt,
	input wire logic goodFrame,
	input wire logic energyDetect,
	input wire logic linkUp,
	input wire logic [NGPIO-1:0] gpioIn,
	// Status toward the chip
	output logic remoteWake,
	output logic [6:0] powerState,
	output logic clkRunning,
	output logic phyPowerDown,
	output logic dropRxFrames,
	output logic readyFlag
);
	// Polarity field sits below the link-up select bit, so it caps the pin count
	if (NGPIO <= `GPIO_LINK || NGPIO > `GW_LINKSEL - `GW_POL_LSB) begin : g_bad_ngpio
		$error("NGPIO out of range");
	end

	wake_pkg::pwr_state_e state_q, state_d;
	logic [1:0] mode_q;
	logic lanWakeEn_q, edEn_q, reinit_q, extPhy_q, fromUncfg_q, remoteWake_q;
	logic [1:0] wakeStatus_q;
	logic [`LAN_EVT_W-1:0] lanEvtEn_q;
	logic [NGPIO-1:0] gpioFlags_q, gpioWakeEn_q, gpioPol_q;
	logic linkSel_q;
	logic [31:0] rdData_q;

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	wire wrPmc = regWrStb && regAddr == `OFS_PMC;
	wire wrWcsr = regWrStb && regAddr == `OFS_WCSR;
	wire wrIsr = regWrStb && regAddr == `OFS_ISR;
	wire wrGwake = regWrStb && regAddr == `OFS_GWAKE;
	wire wrHwcfg = regWrStb && regAddr == `OFS_HWCFG;
	wire [1:0] wsClr = wrPmc ? regWrData[`PMC_WS_LSB+:2] : 2'h0;
	wire [NGPIO-1:0] isrClr = wrIsr ? regWrData[NGPIO-1:0] : '0;

	// ---------------------------------------------------------------
	// State decode
	// ---------------------------------------------------------------
	wire inNormal = state_q == wake_pkg::ST_UNCFG || state_q == wake_pkg::ST_CFG;
	wire inLan = state_q == wake_pkg::ST_SLP_LAN;
	wire inEnergy = state_q == wake_pkg::ST_SLP_ENERGY;
	wire inMin = state_q == wake_pkg::ST_SLP_MIN;
	wire inClk = state_q == wake_pkg::ST_SLP_CLK;
	wire inSleep = inLan || inEnergy || inMin || inClk;
	wire anyLanEvtEn = |lanEvtEn_q;

	// ---------------------------------------------------------------
	// GPIO wake detection
	// ---------------------------------------------------------------
	gpio_wake_if #(.N(NGPIO)) gw ();
	// Pins 0-7 belong to the internal PHY mode only
	wire [NGPIO-1:0] lowPins = {{(NGPIO-`GPIO_INT_HI-1){1'b0}}, {(`GPIO_INT_HI+1){1'b1}}};
	assign gw.usable = extPhy_q ? ~lowPins : '1;
	assign gw.pinIn = gpioIn;
	assign gw.wakeEn = gpioWakeEn_q;
	assign gw.polarity = gpioPol_q;
	assign gw.linkSel = linkSel_q;
	// Link up counts only in the two states that accept it
	assign gw.linkUp = linkUp && (inLan || inClk);

	gpio_wake_detect #(.N(NGPIO)) u_detect (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.bus(gw)
	);

	// ---------------------------------------------------------------
	// Event qualification per state
	// ---------------------------------------------------------------
	// No wake source at all while unpowered
	wire [NGPIO-1:0] gpioSet = state_q == wake_pkg::ST_UNPOWERED ? '0 : gw.evt;
	wire lanSet = (inLan && lanWakeEn_q && lanWakeEvt)
		|| (inClk && !anyLanEvtEn && goodFrame);
	wire edSet = inEnergy && edEn_q && energyDetect;
	// Pending sticky status wakes at once, even right after suspend
	wire wakeNow = (|gpioFlags_q)
		|| (inLan && lanWakeEn_q && wakeStatus_q[`WS_LAN])
		|| (inClk && wakeStatus_q[`WS_LAN])
		|| (inEnergy && edEn_q && wakeStatus_q[`WS_ENERGY]);
	wire [1:0] wsSet = {lanSet, edSet};

	// ---------------------------------------------------------------
	// Suspend target and next state
	// ---------------------------------------------------------------
	wake_pkg::pwr_state_e sleepTarget;
	always_comb begin
		case (mode_q)
			`MODE_LAN: sleepTarget = wake_pkg::ST_SLP_LAN;
			`MODE_ENERGY: sleepTarget = wake_pkg::ST_SLP_ENERGY;
			`MODE_MIN: sleepTarget = wake_pkg::ST_SLP_MIN;
			`MODE_CLK: sleepTarget = wake_pkg::ST_SLP_CLK;
			default: sleepTarget = wake_pkg::ST_SLP_MIN;
		endcase
	end

	wire [6:0] wakeTarget = fromUncfg_q ? wake_pkg::ST_UNCFG : wake_pkg::ST_CFG;

	// Power-state sequencing; loss of bus power overrides all
	always_comb begin
		state_d = state_q;
		case (state_q)
			wake_pkg::ST_UNPOWERED: begin
				state_d = wake_pkg::ST_UNCFG;
			end
			wake_pkg::ST_UNCFG: begin
				if (suspendReq) begin
					state_d = wake_pkg::ST_SLP_MIN;
				end else if (configDone) begin
					state_d = wake_pkg::ST_CFG;
				end
			end
			wake_pkg::ST_CFG: begin
				if (deconfigure) begin
					state_d = wake_pkg::ST_UNCFG;
				end else if (suspendReq) begin
					state_d = sleepTarget;
				end
			end
			wake_pkg::ST_SLP_LAN, wake_pkg::ST_SLP_ENERGY,
			wake_pkg::ST_SLP_MIN, wake_pkg::ST_SLP_CLK: begin
				if (hostResume || wakeNow) begin
					state_d = wake_pkg::pwr_state_e'(wakeTarget);
				end
			end
			default: state_d = wake_pkg::ST_UNCFG;
		endcase
		if (!busPowerSense) begin
			state_d = wake_pkg::ST_UNPOWERED;
		end else if (usbReset) begin
			state_d = wake_pkg::ST_UNCFG;
		end
	end

	wire leaving = inSleep && busPowerSense && !usbReset && (hostResume || wakeNow);
	wire enterMin = state_d == wake_pkg::ST_SLP_MIN && !inMin;

	// State register and origin of the current sleep
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= wake_pkg::ST_UNCFG;
			fromUncfg_q <= 1'b1;
			remoteWake_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (inNormal) begin
				fromUncfg_q <= state_q == wake_pkg::ST_UNCFG;
			end
			// Resume by the host needs no remote wake
			remoteWake_q <= leaving && !hostResume;
		end
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	// Select survives wakes; only reset and deconfiguration restore it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= `MODE_RESET;
		end else if (inNormal && deconfigure) begin
			mode_q <= `MODE_RESET;
		end else if (wrPmc) begin
			mode_q <= regWrData[`PMC_MODE_LSB+:2];
		end
	end

	// Enables and configuration
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lanWakeEn_q <= 1'b0;
			edEn_q <= 1'b0;
			lanEvtEn_q <= '0;
			gpioWakeEn_q <= '0;
			gpioPol_q <= '0;
			linkSel_q <= 1'b0;
			extPhy_q <= 1'b0;
		end else begin
			if (wrPmc) begin
				lanWakeEn_q <= regWrData[`PMC_LANEN];
				edEn_q <= regWrData[`PMC_EDEN];
			end
			if (wrWcsr) begin
				lanEvtEn_q <= regWrData[`LAN_EVT_W-1:0];
			end
			if (wrGwake) begin
				gpioWakeEn_q <= regWrData[NGPIO-1:0];
				gpioPol_q <= regWrData[`GW_POL_LSB+:NGPIO];
				linkSel_q <= regWrData[`GW_LINKSEL];
			end
			if (wrHwcfg) begin
				extPhy_q <= regWrData[`HWCFG_EXTPHY];
			end
		end
	end

	// Sticky status: a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gpioFlags_q <= '0;
			wakeStatus_q <= 2'h0;
			reinit_q <= 1'b0;
		end else begin
			gpioFlags_q <= (gpioFlags_q & ~isrClr) | gpioSet;
			wakeStatus_q <= (wakeStatus_q & ~wsClr) | wsSet;
			reinit_q <= (reinit_q && !(wrPmc && regWrData[`PMC_REINIT])) || enterMin;
		end
	end

	// ---------------------------------------------------------------
	// Read port: data stand only in the cycle after the strobe
	// ---------------------------------------------------------------
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0;
		case (regAddr)
			`OFS_PMC: begin
				rdMux[`PMC_MODE_LSB+:2] = mode_q;
				rdMux[`PMC_LANEN] = lanWakeEn_q;
				rdMux[`PMC_EDEN] = edEn_q;
				rdMux[`PMC_WS_LSB+:2] = wakeStatus_q;
				rdMux[`PMC_READY] = inNormal;
				rdMux[`PMC_REINIT] = reinit_q;
			end
			`OFS_WCSR: rdMux[`LAN_EVT_W-1:0] = lanEvtEn_q;
			`OFS_ISR: rdMux[NGPIO-1:0] = gpioFlags_q;
			`OFS_GWAKE: begin
				rdMux[NGPIO-1:0] = gpioWakeEn_q;
				rdMux[`GW_POL_LSB+:NGPIO] = gpioPol_q;
				rdMux[`GW_LINKSEL] = linkSel_q;
			end
			`OFS_HWCFG: rdMux[`HWCFG_EXTPHY] = extPhy_q;
			`OFS_STATE: rdMux[6:0] = state_q;
			default: rdMux = 32'h0;
		endcase
	end

	// Read data register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_q <= 32'h0;
		end else begin
			rdData_q <= regRdStb ? rdMux : 32'h0;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign regRdData = rdData_q;
	assign remoteWake = remoteWake_q;
	assign powerState = state_q;
	// PLL stays up in clocks-on sleep, trading power for fast frame wake
	assign clkRunning = inNormal || inLan || inClk;
	assign phyPowerDown = inMin || state_q == wake_pkg::ST_UNPOWERED;
	assign dropRxFrames = inClk && anyLanEvtEn;
	assign readyFlag = inNormal;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// Each property names its own clock and reset
	min_select_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_q == wake_pkg::ST_CFG && suspendReq && !deconfigure && mode_q == `MODE_MIN
		&& busPowerSense && !usbReset |=> state_q == wake_pkg::ST_SLP_MIN)
		else $error("10b did not enter minimum sleep");
	min_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		inMin && !hostResume && gpioFlags_q == '0 && busPowerSense && !usbReset
		|=> inMin) else $error("minimum sleep left without cause");
	clk_select_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_q == wake_pkg::ST_CFG && suspendReq && !deconfigure && mode_q == `MODE_CLK
		&& busPowerSense && !usbReset |=> inClk && clkRunning)
		else $error("11b did not enter clocks-on sleep");
	good_frame_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		inClk && goodFrame && !anyLanEvtEn |=> wakeStatus_q[`WS_LAN])
		else $error("good frame left status clear");
	drop_rx_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		inClk && anyLanEvtEn |-> dropRxFrames && !wsSet[`WS_LAN])
		else $error("frames not dropped");
	flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wrIsr |=> (gpioFlags_q & $past(gpioFlags_q)) == $past(gpioFlags_q))
		else $error("gpio flag lost");
	uncfg_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_q == wake_pkg::ST_UNCFG && suspendReq && busPowerSense && !usbReset
		|=> inMin ##1 (inMin || state_q == wake_pkg::ST_UNCFG
		|| state_q == wake_pkg::ST_UNPOWERED)) else $error("bad sleep from unconfigured");
	deconf_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		inNormal && deconfigure |=> mode_q == `MODE_RESET) else $error("select not reset");
	wake_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		remoteWake |-> $past(inSleep) && inNormal ##1 !remoteWake)
		else $error("remote wake misplaced");
endmodule // suspend_wake_event_logic

// ### tb/host_usb_model.sv
// Stand-in for the USB host controller and its driver on the far side.
// Assumes drive() is called right after a rising edge of core_clk.
`timescale 1ns/1ps
module host_usb_model (
	// Clock and wake request from the device
	input wire logic core_clk,
	input wire logic remoteWake,
	// Bus signalling toward the device
	output logic suspendReq,
	output logic hostResume,
	output logic usbReset,
	output logic configDone,
	output logic deconfigure
);
	int wakeCount = 0;

	// Quiet bus at time zero
	initial begin
		suspendReq = 1'h0;
		hostResume = 1'h0;
		usbReset = 1'h0;
		configDone = 1'h0;
		deconfigure = 1'h0;
	end

	// Count request pulses; a request stuck high counts every cycle and so shows up
	always @(posedge core_clk) begin
		if (remoteWake === 1'h1)
			wakeCount++;
	end

	// One host action per call, level held until the caller drives it again
	task drive(input int k, input logic v);
		case (k)
			0: suspendReq <= v;
			1: hostResume <= v;
			2: usbReset <= v;
			3: configDone <= v;
			default: deconfigure <= v;
		endcase
	endtask
endmodule // host_usb_model

// ### tb/tb.sv
// Self-checking bench for the suspend and wake event logic.
// Assumes the host model beside it and the shared constants header.
`timescale 1ns/1ps
`include "wake_params.svh"
module tb;
	logic core_clk, rst_b = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData;
	logic regWrStb = 1'h0, regRdStb = 1'h0;
	logic suspendReq, hostResume, usbReset, configDone, deconfigure;
	logic busPowerSense = 1'h1, lanWakeEvt = 1'h0, goodFrame = 1'h0;
	logic energyDetect = 1'h0, linkUp = 1'h0;
	logic [10:0] gpioIn = 11'h000;
	logic remoteWake, clkRunning, phyPowerDown, dropRxFrames, readyFlag;
	logic [6:0] powerState;
	logic [6:0] stExp [4] = '{wake_pkg::ST_SLP_LAN, wake_pkg::ST_SLP_ENERGY,
		wake_pkg::ST_SLP_MIN, wake_pkg::ST_SLP_CLK};
	int accEv [4] = '{0, 2, 4, 1};
	int ignEv [4] = '{2, 0, 1, 2};
	logic [31:0] wsExp [4] = '{32'h20, 32'h10, 32'h80, 32'h20};
	// Expected {clkRunning, phyPowerDown} per sleep state
	logic [31:0] pwrExp [4] = '{32'h2, 32'h0, 32'h1, 32'h2};
	int errors = 0, total_checks = 0, w0;

	suspend_wake_event_logic #(.NGPIO(11)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData), .suspendReq(suspendReq),
		.hostResume(hostResume), .usbReset(usbReset), .configDone(configDone),
		.deconfigure(deconfigure), .busPowerSense(busPowerSense), .lanWakeEvt(lanWakeEvt),
		.goodFrame(goodFrame), .energyDetect(energyDetect), .linkUp(linkUp),
		.gpioIn(gpioIn), .remoteWake(remoteWake), .powerState(powerState),
		.clkRunning(clkRunning), .phyPowerDown(phyPowerDown),
		.dropRxFrames(dropRxFrames), .readyFlag(readyFlag));

	host_usb_model host (.core_clk(core_clk), .remoteWake(remoteWake),
		.suspendReq(suspendReq), .hostResume(hostResume), .usbReset(usbReset),
		.configDone(configDone), .deconfigure(deconfigure));

	// --------------------------------------------------------------
	// Clock, watchdog, verdict
	// --------------------------------------------------------------
	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end

	// Whole run is a few hundred cycles; 5000 means a hang
	initial begin
		#100000;
		errors++;
		stop_test();
	end

	task stop_test();
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Access tasks
	// --------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'h1;
		@(posedge core_clk);
		regWrStb <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRdStb <= 1'h1;
		@(posedge core_clk);
		regRdStb <= 1'h0;
		#1;
		chk(regRdData, e);
	endtask

	// Events 0..2 from the network side, 3.. from the host model, one cycle each
	task ev(input int k);
		@(posedge core_clk);
		if (k == 0)
			lanWakeEvt <= 1'h1;
		else if (k == 1)
			goodFrame <= 1'h1;
		else if (k == 2)
			energyDetect <= 1'h1;
		else
			host.drive(k - 3, 1'h1);
		@(posedge core_clk);
		lanWakeEvt <= 1'h0;
		goodFrame <= 1'h0;
		energyDetect <= 1'h0;
		if (k > 2)
			host.drive(k - 3, 1'h0);
	endtask

	task st(input logic [6:0] e);
		repeat (3) @(posedge core_clk);
		#1;
		chk(powerState, e);
	endtask

	task pins(input logic [10:0] v);
		@(posedge core_clk);
		gpioIn <= v;
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'h1;
		#1;
		chk(powerState, wake_pkg::ST_UNCFG);
		rd(`OFS_PMC, 32'h42);
		rd(8'h20, 32'h0);
		// Unconfigured suspend always lands in minimum sleep, even with 11b
		wr(`OFS_PMC, 32'h3);
		ev(3);
		st(wake_pkg::ST_SLP_MIN);
		chk({phyPowerDown, clkRunning}, 32'h2);
		ev(1);
		ev(0);
		ev(2);
		st(wake_pkg::ST_SLP_MIN);
		w0 = host.wakeCount;
		ev(4);
		st(wake_pkg::ST_UNCFG);
		chk(host.wakeCount, w0);
		rd(`OFS_PMC, 32'hC3);
		wr(`OFS_PMC, 32'h80);
		ev(6);
		st(wake_pkg::ST_CFG);
		// Each sleep state: one refused source, then one accepted source
		for (int m = 0; m < 4; m++) begin
			wr(`OFS_PMC, 32'hC | m);
			ev(3);
			st(stExp[m]);
			chk({clkRunning, phyPowerDown}, pwrExp[m]);
			ev(ignEv[m]);
			st(stExp[m]);
			w0 = host.wakeCount;
			ev(accEv[m]);
			st(wake_pkg::ST_CFG);
			chk(host.wakeCount, w0 + (m != 2));
			rd(`OFS_PMC, 32'h4C | m | wsExp[m]);
			wr(`OFS_PMC, 32'hB0 | m);
		end
		// Clocks-on sleep with a LAN event enable left set
		wr(`OFS_WCSR, 32'h1);
		ev(3);
		st(wake_pkg::ST_SLP_CLK);
		chk(dropRxFrames, 32'h1);
		ev(4);
		st(wake_pkg::ST_CFG);
		wr(`OFS_WCSR, 32'h0);
		chk({readyFlag, dropRxFrames}, 32'h2);
		// GPIO 3 wake from minimum sleep, then a suspend with its flag pending
		wr(`OFS_GWAKE, 32'h00080008);
		wr(`OFS_PMC, 32'h2);
		ev(3);
		st(wake_pkg::ST_SLP_MIN);
		w0 = host.wakeCount;
		pins(11'h008);
		st(wake_pkg::ST_CFG);
		chk(host.wakeCount, w0 + 1);
		rd(`OFS_ISR, 32'h8);
		rd(`OFS_ISR, 32'h8);
		ev(3);
		st(wake_pkg::ST_CFG);
		wr(`OFS_ISR, 32'h8);
		rd(`OFS_ISR, 32'h0);
		pins(11'h000);
		// External PHY: pins 0-7 cannot wake, 8-10 still can
		wr(`OFS_HWCFG, 32'h1);
		wr(`OFS_GWAKE, 32'h02080208);
		ev(3);
		st(wake_pkg::ST_SLP_MIN);
		pins(11'h008);
		st(wake_pkg::ST_SLP_MIN);
		pins(11'h208);
		st(wake_pkg::ST_CFG);
		rd(`OFS_ISR, 32'h200);
		wr(`OFS_ISR, 32'h7FF);
		pins(11'h000);
		wr(`OFS_HWCFG, 32'h0);
		// GPIO7 standing for link up in LAN-wake sleep
		wr(`OFS_GWAKE, 32'h80800080);
		wr(`OFS_PMC, 32'h0);
		ev(3);
		st(wake_pkg::ST_SLP_LAN);
		@(posedge core_clk);
		linkUp <= 1'h1;
		st(wake_pkg::ST_CFG);
		rd(`OFS_ISR, 32'h80);
		wr(`OFS_ISR, 32'h7FF);
		linkUp <= 1'h0;
		// Deconfiguration puts the select back to 10b
		wr(`OFS_PMC, 32'h3);
		ev(7);
		st(wake_pkg::ST_UNCFG);
		rd(`OFS_PMC, 32'hC2);
		// USB reset from sleep, then loss of bus power
		ev(6);
		ev(3);
		st(wake_pkg::ST_SLP_MIN);
		ev(5);
		st(wake_pkg::ST_UNCFG);
		@(posedge core_clk);
		busPowerSense <= 1'h0;
		st(wake_pkg::ST_UNPOWERED);
		chk({phyPowerDown, readyFlag}, 32'h2);
		ev(4);
		st(wake_pkg::ST_UNPOWERED);
		@(posedge core_clk);
		busPowerSense <= 1'h1;
		st(wake_pkg::ST_UNCFG);
		stop_test();
	end
endmodule // tb
